// ### hw/pcs_top.v
// Summary of operation
// - Every enabled source clocks the pattern; pause also acts on stop flop.
// - Group six readback puts run/stop state on readback and data bit six.
// - Step mode: one step strobe leaves stop flop reading zero.
// - Pause, stop, processor gates low: two step strobes leave status zero.
// - Pause high setup with external settings; two clocks give status zero.
// - Processor load clock selected: two strobes give status 0x08.
// - First analyzer clock gate passes two clocks; status then zero.
// - Second analyzer clock gate passes two clocks; status then zero.
// - External clock gate passes external edges; status then zero.
// - Writing 0xf9 then 0xf8 to gate control clears run flop.
// - Writing 0xfa then 0xf8 to gate control sets run flop.
// - Enabled external start request sets run flop.
// - Group six readback puts the selected inhibit line, inverted, on readback and data bit two.
// - Inhibit select with high inhibit line reads status zero.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "pcs_map.vh"
module pcs_top #(
   parameter AW = 12
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire first_analyzer_clock,
   input wire second_analyzer_clock,
   input wire pattern_external_clock,
   input wire external_start,
   input wire inhibit_in,
   input wire pause_in,
   output reg pattern_clock,
   output reg run_flip_flop,
   output reg stop_flip_flop,
   output reg [7:0] readback_bus,
   output reg readback_bus_en,
   output reg [7:0] aux_out
);
   ////////////////////////////////////////////////////////////////////////
   // Address decode
   // Every register is one aligned word; AW below ten is not supported
   function is_reg;
      input [AW-1:0] a;
      input [7:0] idx;
      begin
         is_reg = (a == {{(AW-10){1'b0}}, idx, 2'b00});
      end
   endfunction

   reg [7:0] gate_q;
   reg [7:0] src_q;
   reg [7:0] aux_q;
   reg [7:0] group_q;
   reg step_q;

   wire setup_ph;
   wire acc;
   wire wr;
   assign setup_ph = psel & ~penable;
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;

   wire hit_status;
   wire hit_step;
   wire hit_gate;
   wire hit_group;
   wire hit_aux;
   wire hit_src;
   wire hit_any;
   assign hit_status = is_reg(paddr, `PCS_IDX_STATUS);
   assign hit_step = is_reg(paddr, `PCS_IDX_STEP);
   assign hit_gate = is_reg(paddr, `PCS_IDX_GATE);
   assign hit_group = is_reg(paddr, `PCS_IDX_GROUP);
   assign hit_aux = is_reg(paddr, `PCS_IDX_AUX);
   assign hit_src = is_reg(paddr, `PCS_IDX_SRC);
   assign hit_any = hit_status | hit_step | hit_gate | hit_group | hit_aux | hit_src;

   // Status is read only: a write to it is dropped without an error
   wire wr_step;
   wire wr_gate;
   wire wr_group;
   wire wr_aux;
   wire wr_src;
   wire rd_status;
   assign wr_step = wr & hit_step;
   assign wr_gate = wr & hit_gate;
   assign wr_group = wr & hit_group;
   assign wr_aux = wr & hit_aux;
   assign wr_src = wr & hit_src;
   assign rd_status = setup_ph & ~pwrite & hit_status;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers and edges
   // Pins are free running: each passes two flops before any logic
   wire [4:0] pins_s;
   wire [0:0] an1_s;
   wire [3:0] pins_r;
   pcs_sync #(.W(5)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({pause_in, inhibit_in, external_start, pattern_external_clock,
         second_analyzer_clock}),
      .q(pins_s)
   );

   pcs_sync #(.W(1)) u_sync1 (
      .pclk(pclk),
      .presetn(presetn),
      .d(first_analyzer_clock),
      .q(an1_s)
   );

   // Only clocks and start act on edges; pause and inhibit are levels
   pcs_edge #(.W(4)) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .lvl({pins_s[2], pins_s[1], pins_s[0], an1_s[0]}),
      .rise(pins_r)
   );

   wire pause_s;
   wire inh_s;
   wire start_r;
   wire ext_r;
   wire an2_r;
   wire an1_r;
   assign pause_s = pins_s[4];
   assign inh_s = pins_s[3];
   assign start_r = pins_r[3];
   assign ext_r = pins_r[2];
   assign an2_r = pins_r[1];
   assign an1_r = pins_r[0];

   ////////////////////////////////////////////////////////////////////////
   // Port registers
   // Step register holds no data: a write is a one cycle strobe
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_q <= 1'b0;
      end else begin
         step_q <= wr_step;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_q <= `PCS_GATE_RST;
      end else if (wr_gate) begin
         gate_q <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= `PCS_SRC_RST;
      end else if (wr_src) begin
         src_q <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_q <= `PCS_AUX_RST;
      end else if (wr_aux) begin
         aux_q <= pwdata[7:0];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         group_q <= `PCS_GROUP_RST;
      end else if (wr_group) begin
         group_q <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gate and source decode
   // Source enables are active low; inhibit select is active high
   wire step_en;
   wire run_clr;
   wire run_set;
   wire an1_en;
   wire an2_en;
   wire ext_en;
   wire start_en;
   wire inh_sel;
   assign step_en = ~gate_q[`PCS_GATE_STEP_EN_N];
   assign run_clr = gate_q[`PCS_GATE_RUN_CLR];
   assign run_set = gate_q[`PCS_GATE_RUN_SET];
   assign an1_en = ~src_q[`PCS_SRC_AN1_EN_N];
   assign an2_en = ~src_q[`PCS_SRC_AN2_EN_N];
   assign ext_en = ~src_q[`PCS_SRC_EXT_EN_N];
   assign start_en = ~src_q[`PCS_SRC_START_EN_N];
   assign inh_sel = src_q[`PCS_SRC_INH_SEL];

   ////////////////////////////////////////////////////////////////////////
   // Clock selection: every enabled source reaches the pattern clock, pulses ORed
   // Load strobes count only with the step gate closed and no pause
   reg clk_pulse;
   reg load_pulse;
   always @* begin
      clk_pulse = 1'b0;
      load_pulse = 1'b0;
      if (step_en & step_q) begin
         clk_pulse = 1'b1;
      end
      if (an1_en & an1_r) begin
         clk_pulse = 1'b1;
      end
      if (an2_en & an2_r) begin
         clk_pulse = 1'b1;
      end
      if (ext_en & ext_r) begin
         clk_pulse = 1'b1;
      end
      if (~step_en & step_q & ~pause_s) begin
         load_pulse = 1'b1;
      end
   end

   wire start_req;
   assign start_req = start_en & start_r;

   ////////////////////////////////////////////////////////////////////////
   // Pattern clock, run and stop flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pattern_clock <= 1'b0;
      end else begin
         pattern_clock <= clk_pulse;
      end
   end

   // Clear wins over set, also against a start request
   // Run state survives pause; only the gate clear and set bits and start change it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_flip_flop <= 1'b0;
      end else if (run_clr) begin
         run_flip_flop <= 1'b0;
      end else if (run_set | start_req) begin
         run_flip_flop <= 1'b1;
      end
   end

   // Clocked sources and pause clear stop; load clock marks it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_flip_flop <= 1'b0;
      end else if (clk_pulse | pause_s) begin
         stop_flip_flop <= 1'b0;
      end else if (load_pulse) begin
         stop_flip_flop <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readback mux
   // Inhibit shows as a one while its line is low and it is selected
   wire grp6;
   assign grp6 = (group_q == `PCS_GROUP_SIX);
   reg [7:0] rb;
   always @* begin
      rb = 8'h00;
      case (group_q)
         `PCS_GROUP_SIX: begin
            rb[`PCS_ST_RUN] = run_flip_flop;
            rb[`PCS_ST_STOP] = stop_flip_flop;
            rb[`PCS_ST_INH] = inh_sel & ~inh_s;
         end
         default: begin
            rb = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Far side readback and aux outputs
   // Registered so that the far side sees glitch free levels
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         readback_bus <= 8'h00;
      end else begin
         readback_bus <= rb;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         readback_bus_en <= 1'b0;
      end else begin
         readback_bus_en <= grp6;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_out <= `PCS_AUX_RST;
      end else begin
         aux_out <= aux_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, no wait states
   // Ready is a pulse: every access ends at the edge after its setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_ph;
      end
   end

   // Unmapped offsets answer with an error and read as zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_ph & ~hit_any;
      end
   end

   // Read data is captured in the setup cycle and held for the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_status) begin
         prdata <= {24'h000000, rb};
      end else begin
         prdata <= 32'h00000000;
      end
   end
endmodule // pcs_top

// ### hw/pcs_map.vh
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
// Register word indices (printed values are not all multiples of four: byte address is index times four)
`define PCS_IDX_STATUS 8'h03
`define PCS_IDX_STEP 8'h04
`define PCS_IDX_GATE 8'h07
`define PCS_IDX_GROUP 8'h08
`define PCS_IDX_AUX 8'h0c
`define PCS_IDX_SRC 8'h0d
// Clock gate control fields
`define PCS_GATE_RUN_CLR 0
`define PCS_GATE_RUN_SET 1
`define PCS_GATE_STEP_EN_N 3
// Clock source control fields: enables active low, inhibit select active high
`define PCS_SRC_INH_SEL 0
`define PCS_SRC_START_EN_N 4
`define PCS_SRC_AN1_EN_N 3
`define PCS_SRC_AN2_EN_N 6
`define PCS_SRC_EXT_EN_N 7
// Readback group select value
`define PCS_GROUP_SIX 8'h40
// Status bit positions
`define PCS_ST_STOP 3
`define PCS_ST_RUN 6
`define PCS_ST_INH 2
// Reset values
`define PCS_GATE_RST 8'hf8
`define PCS_SRC_RST 8'hff
`define PCS_AUX_RST 8'hff
`define PCS_GROUP_RST 8'h00
`endif

// ### hw/pcs_sync.v
`timescale 1ns/1ps
module pcs_sync #(
   parameter W = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // pcs_sync

// ### hw/pcs_edge.v
`timescale 1ns/1ps
// Rising edge detector on already synchronised levels
module pcs_edge #(
   parameter W = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] lvl,
   output wire [W-1:0] rise
);
   reg [W-1:0] prev_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= {W{1'b0}};
      end else begin
         prev_q <= lvl;
      end
   end
   assign rise = lvl & ~prev_q;
endmodule // pcs_edge

// ### tb/pcs_chk_asserts.sv
`timescale 1ns/1ps
module pcs_chk #(parameter AW = 12) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire pattern_clock,
   input wire run_flip_flop,
   input wire stop_flip_flop,
   input wire [7:0] readback_bus,
   input wire readback_bus_en,
   input wire [7:0] aux_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pready && pwrite;
   wire wr_gate = wr && paddr == 'h1c;
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |-> psel && penable ##1 !pready)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_run_clear: assert property (wr_gate && pwdata[0] |-> ##[1:2] !run_flip_flop)
      else $error("run not cleared");
   a_run_set: assert property (wr_gate && pwdata[1:0] == 2'b10 |-> ##[1:2] run_flip_flop)
      else $error("run not set");
   a_rb_run: assert property (readback_bus_en && $stable(run_flip_flop) |-> readback_bus[6] == run_flip_flop)
      else $error("run readback wrong");
   a_rb_stop: assert property (readback_bus_en && $stable(stop_flip_flop) |-> readback_bus[3] == stop_flip_flop)
      else $error("stop readback wrong");
   a_aux_write: assert property (wr && paddr == 'h30 |-> ##2 aux_out == $past(pwdata[7:0], 2))
      else $error("aux not written");
   a_clk_pulse: assert property (pattern_clock |=> !pattern_clock) else $error("clock pulse too long");
endmodule // pcs_chk
bind pcs_top pcs_chk #(.AW(AW)) u_chk (.*);

// ### tb/pcs_board.sv
`timescale 1ns/1ps
module pcs_board (
   input wire pclk,
   output reg [5:0] lines
);
   // Idle: clocks low, pause low, inhibit high so status bit two stays clear
   initial lines = 6'h10;
   task edge_out(input integer i);
      begin
         lines[i] <= 1'b1;
         repeat (6) @(posedge pclk);
         lines[i] <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask
   task level(input integer i, input v);
      lines[i] <= v;
   endtask
endmodule // pcs_board

// ### tb/pattern_clock_select_run_control_tb.sv
`timescale 1ns/1ps
module pattern_clock_select_run_control_tb;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mr = 0, ms = 0, e;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rd;
   reg [7:0] mg = 8'hf8, msr = 8'hff, r8;
   wire [31:0] prdata;
   wire pready, pslverr, pattern_clock, run_flip_flop, stop_flip_flop, readback_bus_en;
   wire [7:0] readback_bus, aux_out, src [0:2];
   wire [5:0] ln;
   integer err_count = 0, tests_run = 0, pc_n = 0, i;
   assign src[0] = 8'hd4;
   assign src[1] = 8'hb4;
   assign src[2] = 8'h74;
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk) if (pattern_clock === 1'b1) pc_n = pc_n + 1;
   pcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_analyzer_clock(ln[0]), .second_analyzer_clock(ln[1]), .pattern_external_clock(ln[2]),
      .external_start(ln[3]), .inhibit_in(ln[4]), .pause_in(ln[5]), .pattern_clock(pattern_clock),
      .run_flip_flop(run_flip_flop), .stop_flip_flop(stop_flip_flop), .readback_bus(readback_bus),
      .readback_bus_en(readback_bus_en), .aux_out(aux_out));
   pcs_board brd (.pclk(pclk), .lines(ln));
   task chk(input [31:0] g, input [31:0] x);
      begin
         #1 tests_run = tests_run + 1;
         if (g !== x) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [7:0] d);
      begin
         @(posedge pclk);
         {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         e = pslverr;
         {psel, penable} <= 2'b00;
         // Let registered outputs settle before anyone compares them
         @(posedge pclk);
         #1;
         // Model of run, stop and inhibit select state
         if (w && a == 12'h034) msr = d;
         if (w && a == 12'h01c) begin
            mg = d;
            if (d[0]) mr = 0;
            else if (d[1]) mr = 1;
         end
         if (w && a == 12'h010 && mg[3] && !ln[5]) ms = 1;
      end
   endtask
   task rs;
      begin
         apb(0, 12'h00c, 0);
         chk(rd, {25'h0, mr, 2'b00, ms, msr[0] & ~ln[4], 2'b00});
      end
   endtask
   task print_verdict;
      begin
         $display("Counts: %0d compared, %0d mismatched", tests_run, err_count);
         if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #60000 err_count = err_count + 1;
      print_verdict;
   end
   initial begin
      i = $urandom(32'hee9c);
      repeat (4) @(posedge pclk);
      presetn <= 1;
      chk(aux_out, 8'hff);
      chk(readback_bus_en, 0);
      apb(1, 12'h020, 8'h40);
      chk(readback_bus_en, 1);
      rs;
      apb(1, 12'h01c, 8'hfa);
      apb(1, 12'h01c, 8'hf8);
      rs;
      apb(1, 12'h01c, 8'hf9);
      apb(1, 12'h01c, 8'hf8);
      rs;
      apb(1, 12'h01c, 8'hf0);
      apb(1, 12'h010, 8'h00);
      rs;
      repeat (2) apb(1, 12'h010, 8'h00);
      rs;
      apb(1, 12'h01c, 8'he8);
      apb(1, 12'h030, 8'hcf);
      apb(1, 12'h034, 8'hf0);
      repeat (2) apb(1, 12'h010, 8'h00);
      rs;
      brd.level(5, 1);
      ms = 0;
      repeat (2) apb(1, 12'h010, 8'h00);
      rs;
      brd.level(5, 0);
      apb(1, 12'h01c, 8'hf8);
      for (i = 0; i < 3; i = i + 1) begin
         apb(1, 12'h034, src[i]);
         pc_n = 0;
         repeat (2) brd.edge_out(i);
         chk(pc_n, 2);
         rs;
      end
      apb(1, 12'h034, 8'hf5);
      rs;
      brd.level(4, 0);
      repeat (3) @(posedge pclk);
      rs;
      brd.level(4, 1);
      apb(1, 12'h034, 8'he4);
      brd.edge_out(3);
      mr = 1;
      rs;
      r8 = $urandom;
      apb(1, 12'h030, r8);
      chk(aux_out, r8);
      apb(0, 12'h004, 0);
      chk({rd, 31'h0, e}, {32'h0, 32'h1});
      apb(1, 12'h020, 8'h00);
      chk(readback_bus_en, 0);
      print_verdict;
   end
endmodule // pattern_clock_select_run_control_tb
